// ===== sht_params.svh
`ifndef SHT_PARAMS_SVH
`define SHT_PARAMS_SVH

// register byte offsets
`define SHT_OFF_BAUD_CTRL   8'h00
`define SHT_OFF_RX_STAT     8'h04
`define SHT_OFF_DIV_LOW     8'h08
`define SHT_OFF_DIV_HIGH    8'h0C
`define SHT_OFF_TX_DATA     8'h10
`define SHT_OFF_TX_STAT     8'h14
`define SHT_OFF_FLAGS       8'h18

// transmit status/control fields
`define SHT_TXS_HOST    7
`define SHT_TXS_NINE    6
`define SHT_TXS_TX_ON   5
`define SHT_TXS_SYNC    4
`define SHT_TXS_FAST    2
`define SHT_TXS_EMPTY   1
`define SHT_TXS_BIT9    0
// receive status/control fields
`define SHT_RXS_PORT_ON 7
`define SHT_RXS_RX9     6
`define SHT_RXS_ONE_RX  5
`define SHT_RXS_CONT_RX 4
// baud control fields
`define SHT_BC_DPOL     5
`define SHT_BC_CPOL     4
`define SHT_BC_WIDE     3
// flags register fields
`define SHT_FL_TXIF    0
`define SHT_FL_DLVL    1

// reset values
`define SHT_RST_CTRL   8'h00
`define SHT_RST_DIV    8'h00

// generator period multipliers, in pclk cycles per divisor step
`define SHT_MUL_LL     20'h00010
`define SHT_MUL_MID    20'h00004
`define SHT_MUL_HH     20'h00001
`define SHT_MIN_PERIOD 20'h00002

`endif

// ===== sht_pkg.sv
package sht_pkg;

  typedef enum logic [1:0]
  {
    SHT_IDLE  = 2'b01,
    SHT_SHIFT = 2'b10
  } sht_state_e;

  typedef logic [19:0] sht_period_t;

endpackage

// ===== sht_sync2.sv
`timescale 1ns/1ns
module sht_sync2
(
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic async_in,
  output logic      sync_out
);

  logic meta_reg;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta_reg <= 1'b0;
      sync_out <= 1'b0;
    end
    else
    begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule

// ===== sht_baud_gen.sv
`timescale 1ns/1ns
`include "sht_params.svh"
module sht_baud_gen
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        restart,
  input  wire logic [15:0] divisor,
  input  wire logic        wide,
  input  wire logic        high_speed,
  output logic             half_tick,
  output logic             bit_tick
);

  sht_pkg::sht_period_t mult;
  sht_pkg::sht_period_t period;
  sht_pkg::sht_period_t cnt_reg;
  logic [15:0]          div_eff;

  always_comb
  begin
    div_eff = wide ? divisor : {8'h00, divisor[7:0]};
    case ({wide, high_speed})
      2'b00:   mult = `SHT_MUL_LL;
      2'b11:   mult = `SHT_MUL_HH;
      default: mult = `SHT_MUL_MID;
    endcase
    period = 20'((({4'h0, div_eff} + 20'h00001) * mult));
    // a half period must be at least one cycle
    if (period < `SHT_MIN_PERIOD)
      period = `SHT_MIN_PERIOD;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_reg   <= 20'h00000;
      half_tick <= 1'b0;
      bit_tick  <= 1'b0;
    end
    else if (restart)
    begin
      cnt_reg   <= 20'h00001;
      half_tick <= 1'b0;
      bit_tick  <= 1'b0;
    end
    else
    begin
      cnt_reg   <= (cnt_reg >= period - 20'h00001) ? 20'h00000 : cnt_reg + 20'h00001;
      half_tick <= (cnt_reg == (period >> 1) - 20'h00001);
      bit_tick  <= (cnt_reg == period - 20'h00001);
    end
  end

endmodule

// ===== sht_tx_top.sv
// The address map and the APB register port are this design's own decisions.
`timescale 1ns/1ns
`include "sht_params.svh"
module sht_tx_top
#(
  parameter int ADDR_W = 8
)
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              data_pin_in,
  output logic                   data_pin_out,
  output logic                   data_pin_oe,
  output logic                   clock_pin_out,
  output logic                   clock_pin_oe,
  output logic                   transmit_interrupt_flag
);

  // ****************************************************************
  // software registers
  // ****************************************************************
  logic [7:0] baud_ctrl_reg;
  logic [7:0] rx_stat_reg;
  logic [7:0] div_low_reg;
  logic [7:0] div_high_reg;
  logic [7:0] tx_ctrl_reg;
  logic [7:0] hold_data_reg;
  logic       hold_full_reg;

  // ****************************************************************
  // shifter state, never mapped for software
  // ****************************************************************
  sht_pkg::sht_state_e state_reg;
  logic [8:0]          shift_reg;
  logic [3:0]          bits_left_reg;
  logic                clk_act_reg;
  logic                data_bit_reg;

  logic        wr_en;
  logic        setup_rd;
  logic        addr_ok;
  logic [7:0]  rd_byte;
  logic        sync_mode;
  logic        host;
  logic        port_en;
  logic        rx_req;
  logic        tx_active;
  logic        last_bit;
  logic        load_now;
  logic        hold_wr;
  logic        half_tick;
  logic        bit_tick;
  logic        data_lvl;
  logic [3:0]  char_bits;
  logic [7:0]  flags_byte;

  // ****************************************************************
  // mode decode
  // ****************************************************************
  assign sync_mode = tx_ctrl_reg[`SHT_TXS_SYNC];
  assign host      = tx_ctrl_reg[`SHT_TXS_HOST];
  assign port_en   = rx_stat_reg[`SHT_RXS_PORT_ON];
  // either receive enable turns the line around for reception
  assign rx_req    = rx_stat_reg[`SHT_RXS_ONE_RX] | rx_stat_reg[`SHT_RXS_CONT_RX];
  assign tx_active = port_en & sync_mode & host & ~rx_req &
                     tx_ctrl_reg[`SHT_TXS_TX_ON];
  assign char_bits = tx_ctrl_reg[`SHT_TXS_NINE] ? 4'h9 : 4'h8;

  // ****************************************************************
  // apb decode
  // ****************************************************************
  assign wr_en    = psel & penable & pready & pwrite;
  assign setup_rd = psel & ~penable;
  assign hold_wr  = wr_en & (paddr == ADDR_W'(`SHT_OFF_TX_DATA));

  always_comb
  begin
    addr_ok = 1'b1;
    case (paddr)
      ADDR_W'(`SHT_OFF_BAUD_CTRL): rd_byte = baud_ctrl_reg;
      ADDR_W'(`SHT_OFF_RX_STAT):   rd_byte = rx_stat_reg;
      ADDR_W'(`SHT_OFF_DIV_LOW):   rd_byte = div_low_reg;
      ADDR_W'(`SHT_OFF_DIV_HIGH):  rd_byte = div_high_reg;
      // holding register is write only
      ADDR_W'(`SHT_OFF_TX_DATA):   rd_byte = 8'h00;
      ADDR_W'(`SHT_OFF_TX_STAT):   rd_byte = tx_ctrl_reg;
      ADDR_W'(`SHT_OFF_FLAGS):     rd_byte = flags_byte;
      default:
      begin
        rd_byte = 8'h00;
        addr_ok = 1'b0;
      end
    endcase
  end

  always_comb
  begin
    flags_byte = 8'h00;
    flags_byte[`SHT_FL_TXIF] = ~hold_full_reg;
    flags_byte[`SHT_FL_DLVL] = data_lvl;
  end

  // read data is caught in the setup cycle so the slave needs no wait state
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
      pready  <= 1'b0;
    end
    else
    begin
      pready <= 1'b1;
      if (setup_rd)
      begin
        prdata  <= pwrite ? 32'h00000000 : {24'h000000, rd_byte};
        pslverr <= ~addr_ok;
      end
    end
  end

  // ****************************************************************
  // control registers
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      baud_ctrl_reg <= `SHT_RST_CTRL;
      rx_stat_reg   <= `SHT_RST_CTRL;
      div_low_reg   <= `SHT_RST_DIV;
      div_high_reg  <= `SHT_RST_DIV;
    end
    else if (wr_en)
    begin
      case (paddr)
        ADDR_W'(`SHT_OFF_BAUD_CTRL):
        begin
          baud_ctrl_reg[`SHT_BC_DPOL]  <= pwdata[`SHT_BC_DPOL];
          baud_ctrl_reg[`SHT_BC_CPOL]  <= pwdata[`SHT_BC_CPOL];
          baud_ctrl_reg[`SHT_BC_WIDE]  <= pwdata[`SHT_BC_WIDE];
        end
        ADDR_W'(`SHT_OFF_RX_STAT):
        begin
          rx_stat_reg[`SHT_RXS_PORT_ON] <= pwdata[`SHT_RXS_PORT_ON];
          rx_stat_reg[`SHT_RXS_RX9]     <= pwdata[`SHT_RXS_RX9];
          rx_stat_reg[`SHT_RXS_ONE_RX]  <= pwdata[`SHT_RXS_ONE_RX];
          rx_stat_reg[`SHT_RXS_CONT_RX] <= pwdata[`SHT_RXS_CONT_RX];
        end
        ADDR_W'(`SHT_OFF_DIV_LOW):  div_low_reg  <= pwdata[7:0];
        ADDR_W'(`SHT_OFF_DIV_HIGH): div_high_reg <= pwdata[7:0];
        default:
        begin
        end
      endcase
    end
  end

  // the empty-status bit is owned by the shifter, software writes skip it
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_ctrl_reg <= `SHT_RST_CTRL;
    end
    else
    begin
      tx_ctrl_reg[`SHT_TXS_EMPTY] <= (state_reg == sht_pkg::SHT_IDLE) & ~load_now;
      if (wr_en && paddr == ADDR_W'(`SHT_OFF_TX_STAT))
      begin
        tx_ctrl_reg[`SHT_TXS_HOST]  <= pwdata[`SHT_TXS_HOST];
        tx_ctrl_reg[`SHT_TXS_NINE]  <= pwdata[`SHT_TXS_NINE];
        tx_ctrl_reg[`SHT_TXS_TX_ON] <= pwdata[`SHT_TXS_TX_ON];
        tx_ctrl_reg[`SHT_TXS_SYNC]  <= pwdata[`SHT_TXS_SYNC];
        tx_ctrl_reg[`SHT_TXS_FAST]  <= pwdata[`SHT_TXS_FAST];
        tx_ctrl_reg[`SHT_TXS_BIT9]  <= pwdata[`SHT_TXS_BIT9];
      end
    end
  end

  // ****************************************************************
  // holding register
  // ****************************************************************
  // a write in the same cycle as a transfer keeps the holding register full
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      hold_data_reg <= 8'h00;
      hold_full_reg <= 1'b0;
    end
    else
    begin
      if (hold_wr)
        hold_data_reg <= pwdata[7:0];
      if (hold_wr)
        hold_full_reg <= 1'b1;
      else if (load_now)
        hold_full_reg <= 1'b0;
    end
  end

  // ****************************************************************
  // bit timing
  // ****************************************************************
  sht_baud_gen u_baud
  (
    .pclk       (pclk),
    .presetn    (presetn),
    .restart    (load_now),
    .divisor    ({div_high_reg, div_low_reg}),
    .wide       (baud_ctrl_reg[`SHT_BC_WIDE]),
    .high_speed (tx_ctrl_reg[`SHT_TXS_FAST]),
    .half_tick  (half_tick),
    .bit_tick   (bit_tick)
  );

  // ****************************************************************
  // shifter
  // ****************************************************************
  assign last_bit = (bits_left_reg == 4'h1);
  // back to back characters load on the last bit's closing tick
  assign load_now = hold_full_reg & tx_active &
                    ((state_reg == sht_pkg::SHT_IDLE) ||
                     (state_reg == sht_pkg::SHT_SHIFT && bit_tick && last_bit));

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_reg     <= sht_pkg::SHT_IDLE;
      shift_reg     <= 9'h000;
      bits_left_reg <= 4'h0;
      clk_act_reg   <= 1'b0;
      data_bit_reg  <= 1'b0;
    end
    else
    begin
      case (state_reg)
        sht_pkg::SHT_IDLE:
        begin
          clk_act_reg <= 1'b0;
          if (load_now)
          begin
            // plain data bits, lsb first, no framing
            shift_reg     <= {tx_ctrl_reg[`SHT_TXS_BIT9], hold_data_reg};
            bits_left_reg <= char_bits;
            data_bit_reg  <= hold_data_reg[0];
            clk_act_reg   <= 1'b1;
            state_reg     <= sht_pkg::SHT_SHIFT;
          end
        end
        sht_pkg::SHT_SHIFT:
        begin
          if (!tx_active)
          begin
            // dropping the mode aborts the character, clock back to idle
            clk_act_reg <= 1'b0;
            state_reg   <= sht_pkg::SHT_IDLE;
          end
          else if (load_now)
          begin
            shift_reg     <= {tx_ctrl_reg[`SHT_TXS_BIT9], hold_data_reg};
            bits_left_reg <= char_bits;
            data_bit_reg  <= hold_data_reg[0];
            clk_act_reg   <= 1'b1;
          end
          else if (bit_tick)
          begin
            if (last_bit)
            begin
              clk_act_reg <= 1'b0;
              state_reg   <= sht_pkg::SHT_IDLE;
            end
            else
            begin
              // leading edge: next bit and active clock together
              shift_reg     <= {1'b0, shift_reg[8:1]};
              data_bit_reg  <= shift_reg[1];
              bits_left_reg <= bits_left_reg - 4'h1;
              clk_act_reg   <= 1'b1;
            end
          end
          else if (half_tick)
          begin
            clk_act_reg <= 1'b0; // trailing edge, data held
          end
        end
        default:
        begin
          state_reg   <= sht_pkg::SHT_IDLE;
          clk_act_reg <= 1'b0;
        end
      endcase
    end
  end

  // ****************************************************************
  // pins
  // ****************************************************************
  // data and clock pass the same one-cycle stage, so their phase is kept
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      clock_pin_out <= 1'b0;
      clock_pin_oe  <= 1'b0;
      data_pin_out  <= 1'b0;
      data_pin_oe   <= 1'b0;
    end
    else
    begin
      // idle level equals the polarity bit, active level its inverse
      // a cut character parks the clock in the same cycle the data driver is released, never a stale active level
      clock_pin_out <= (clk_act_reg & tx_active) ^ baud_ctrl_reg[`SHT_BC_CPOL];
      clock_pin_oe  <= port_en & sync_mode & host;
      data_pin_out  <= data_bit_reg ^ baud_ctrl_reg[`SHT_BC_DPOL];
      data_pin_oe   <= tx_active;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      transmit_interrupt_flag <= 1'b1;
    else
      transmit_interrupt_flag <= ~(hold_full_reg | hold_wr);
  end

  // ****************************************************************
  // line level seen on the data pin
  // ****************************************************************
  logic data_pin_sync;

  sht_sync2 u_data_sync
  (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (data_pin_in),
    .sync_out (data_pin_sync)
  );

  // received data follows the same polarity selection
  assign data_lvl = data_pin_sync ^ baud_ctrl_reg[`SHT_BC_DPOL];

endmodule

// ===== sht_tx_checker.sv
`timescale 1ns/1ns
// ****************************************
// port checker for the host transmit block
// ****************************************
module sht_tx_checker
#(
  parameter int ADDR_W = 8
)
(
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic              data_pin_out,
  input wire logic              data_pin_oe,
  input wire logic              clock_pin_out,
  input wire logic              clock_pin_oe,
  input wire logic              transmit_interrupt_flag
);
  logic cpol_q;
  logic cpol_q2;
  logic rx_q;
  wire  wr      = psel && penable && pwrite && pready;
  wire  wr_hold = wr && paddr == 8'h10;
  // shadow copies of control bits; the outputs lag them by one register stage
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cpol_q  <= 1'h0;
      cpol_q2 <= 1'h0;
    end
    else
    begin
      cpol_q2 <= cpol_q;
      if (wr && paddr == 8'h00)
        cpol_q <= pwdata[4];
    end
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rx_q <= 1'h0;
    else if (wr && paddr == 8'h04)
      rx_q <= pwdata[5] | pwdata[4];
  end
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_lead;
    $past(clock_pin_out) == cpol_q && clock_pin_out != cpol_q;
  endsequence
  chk_ready_after_setup: assert property (s_setup |=> pready)
    else $error("pready missing in access phase");
  chk_unmapped_error: assert property (s_setup ##0 paddr >= 8'h1C |=> pslverr)
    else $error("no error for unmapped address");
  chk_clock_idle_level: assert property (clock_pin_oe && !data_pin_oe
    && !$past(data_pin_oe) && cpol_q == cpol_q2 |-> clock_pin_out == cpol_q)
    else $error("clock not at idle level");
  chk_data_needs_clock: assert property (data_pin_oe |-> clock_pin_oe)
    else $error("data driven without clock driver");
  chk_half_duplex: assert property (rx_q && $past(rx_q) |-> !data_pin_oe)
    else $error("data driven while receive set");
  chk_data_on_lead: assert property (data_pin_oe && $past(data_pin_oe)
    && cpol_q == cpol_q2 && $changed(data_pin_out) |-> s_lead)
    else $error("data changed off leading edge");
  chk_flag_after_write: assert property ($fell(transmit_interrupt_flag)
    |-> $past(wr_hold) || $past(wr_hold, 2))
    else $error("holding flag fell without write");
  chk_active_clock_oe: assert property (clock_pin_out != cpol_q
    && cpol_q == cpol_q2 |-> clock_pin_oe)
    else $error("clock active without driver");
endmodule
bind sht_tx_top sht_tx_checker #(.ADDR_W(ADDR_W)) chk_u (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pready(pready), .pslverr(pslverr), .data_pin_out(data_pin_out),
  .data_pin_oe(data_pin_oe), .clock_pin_out(clock_pin_out), .clock_pin_oe(clock_pin_oe),
  .transmit_interrupt_flag(transmit_interrupt_flag));

// ===== sht_client_model.sv
`timescale 1ns/1ns
// *****************************
// clocked client on the far side
// *****************************
module sht_client_model
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clear,
  input  wire logic        cpol,
  input  wire logic        dpol,
  input  wire logic        clk_line,
  input  wire logic        data_out,
  input  wire logic        data_oe,
  output logic             line_level,
  output logic [17:0]      got,
  output logic [7:0]       edges,
  output logic [15:0]      active
);
  logic clk_prev;
  logic wobble;
  // the client never drives here; a released line wobbles so stale values show
  assign line_level = data_oe ? data_out : wobble;
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wobble <= 1'h0;
      clk_prev <= 1'h0;
      got <= 18'h0;
      edges <= 8'h00;
      active <= 16'h0;
    end
    else
    begin
      wobble <= ~wobble;
      clk_prev <= clk_line;
      if (clear)
      begin
        got <= 18'h0;
        edges <= 8'h00;
        active <= 16'h0;
      end
      else
      begin
        if (clk_line != cpol)
          active <= active + 16'h1;
        if (clk_prev == cpol && clk_line != cpol)
          edges <= edges + 8'h01;
        // sample on the trailing edge, lsb first, polarity undone
        if (clk_prev != cpol && clk_line == cpol)
          got <= {line_level ^ dpol, got[17:1]};
      end
    end
  end
endmodule

// ===== sht_tx_top_bench.sv
`timescale 1ns/1ns
// ***************
// host transmit test
// ***************
module sht_tx_top_bench;
  logic        pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [7:0]  paddr = 8'h00, a, b;
  logic [31:0] pwdata = 32'h0, prdata, rdat, seed = 32'h0000000D;
  logic        pready, pslverr, errq, din, dout, doe, cko, ckoe, txif, b9, n9;
  logic        clr = 1'h1, cpol = 1'h0, dpol = 1'h0;
  logic [17:0] got;
  logic [7:0]  edges;
  logic [15:0] active;
  int          failures = 0, total_checks = 0, n;
  always #50 pclk = ~pclk;
  sht_tx_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .data_pin_in(din), .data_pin_out(dout), .data_pin_oe(doe),
    .clock_pin_out(cko), .clock_pin_oe(ckoe), .transmit_interrupt_flag(txif));
  sht_client_model cli_u (.pclk(pclk), .presetn(presetn), .clear(clr), .cpol(cpol),
    .dpol(dpol), .clk_line(cko), .data_out(dout), .data_oe(doe), .line_level(din),
    .got(got), .edges(edges), .active(active));
  function logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [17:0] frame(input logic [7:0] f, s, input logic w9, d9);
    return w9 ? {d9, s, d9, f} : {2'h0, s, f};
  endfunction
  task check(input logic [31:0] g, e, input string m);
    total_checks++;
    if (g !== e)
    begin
      failures++;
      $display("[ERR] %0t %s: got %h expected %h", $time, m, g, e);
    end
  endtask
  task apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    // only the watchdog ends a wait for the answer
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'h1);
    rdat = prdata;
    errq = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task test_done();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    #2000000;
    failures++;
    test_done();
  end
  initial
  begin
    repeat (12) @(posedge pclk);
    presetn <= 1'h1;
    apb(0, 8'h00, 0); check(rdat, 32'h0, "baud control reset");
    apb(0, 8'h14, 0); check(rdat, 32'h2, "tx status reset");
    apb(0, 8'h18, 0); check(rdat[0], 1'h1, "holding empty at reset");
    apb(0, 8'h10, 0); check(rdat, 32'h0, "holding reads zero");
    apb(0, 8'h1C, 0); check(errq, 1'h1, "unmapped access");
    apb(1, 8'h08, 32'h07); // one bit time is eight pclk cycles
    apb(1, 8'h0C, 32'h00);
    for (int k = 0; k < 8; k++)
    begin
      cpol <= k[0];
      dpol <= k[1];
      n9 = k[2];
      a = xs();
      b = xs();
      b9 = xs();
      clr <= 1'h1;
      apb(1, 8'h14, 0);
      apb(1, 8'h00, {26'h0, k[1], k[0], 4'h8});
      apb(1, 8'h04, 32'h80);
      apb(1, 8'h14, {24'h0, 1'h1, n9, 4'hD, 1'h0, b9});
      clr <= 1'h0;
      apb(1, 8'h10, a);
      apb(1, 8'h10, b);
      apb(0, 8'h14, 0); check(rdat[1], 1'h0, "busy status");
      n = 0;
      do
      begin
        apb(0, 8'h14, 0);
        n++;
      end
      while (rdat[1] !== 1'h1 && n < 100);
      check(edges, n9 ? 8'h12 : 8'h10, "clock count");
      check(active, n9 ? 16'h48 : 16'h40, "active clock time");
      check(got >> (n9 ? 0 : 2), frame(a, b, n9, b9), "bits seen");
      check(cko, cpol, "clock idle level");
      check(txif, 1'h1, "holding empty after");
      apb(0, 8'h18, 0);
      check(rdat[1], n9 ? b9 : b[7], "line level seen");
    end
    apb(1, 8'h04, 32'h90);
    apb(1, 8'h10, xs());
    repeat (40) @(posedge pclk);
    check(doe, 1'h0, "data released in receive");
    check(ckoe, 1'h1, "clock driven in receive");
    apb(1, 8'h04, 32'h00);
    repeat (3) @(posedge pclk);
    check(ckoe, 1'h0, "port disabled");
    apb(1, 8'h04, 32'h80);
    apb(1, 8'h14, 32'h24);
    repeat (3) @(posedge pclk);
    check({ckoe, doe}, 2'h0, "asynchronous mode");
    test_done();
  end
endmodule
